// ===== hw/tfp_timer_flags.sv
// Timer flag registers, shared prescaler and per-timer clock selection.
// Assumes counter units supply match, overflow and capture events on this clock.
// Behaviour
// - Compare C irq needs enable, global, flag
// - Capture flag on capture or TOP
// - Compare flag set on timer clock after match
// - Forced compare never sets flags
// - Vector execution or write-one clears flag
// - Overflow flag set on counter overflow
// - One shared prescaler, independent selects
// - Select one gives undivided clock
// - Taps at divide 8,64,256,1024
// - Prescaler free-running, first count delayed
// - Prescaler reset restarts all prescaled timers
// - Pin sampled through synchroniser registers
// - Select 7 rising, 6 falling edges
// - Pin edge latency 2.5 to 3.5 clocks
// - External edges bypass prescaler
// - Select zero stops timer clock
// - Reset bit self-clears unless sync mode
// - Clearing sync mode releases reset bit
`timescale 1ns/1ps
`include "tfp_params.svh"
module tfp_timer_flags
    import tfp_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [7:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire tfp_events_type t1_events,
    input wire tfp_events_type t3_events,
    input wire tfp_ack_type t1_ack,
    input wire tfp_ack_type t3_ack,
    input wire logic forced_compare_strobe,
    input wire logic global_irq_enable,
    input wire logic t1_ext_timer_clock_pin,
    input wire logic t2_ext_timer_clock_pin,
    input wire logic t3_ext_timer_clock_pin,
    output logic [2:0] timer_clocks,
    output logic t1_compare_c_irq
);
    logic [7:0] flags;
    logic [7:0] ext_flags;
    logic t1_compare_c_irq_enable;
    logic sync_mode_bit;
    logic shared_prescaler_reset_bit;
    logic [8:0] clock_selects;
    logic answered;
    logic [7:0] next_flags;
    logic [7:0] next_ext_flags;
    logic next_irq_enable;
    logic next_sync_mode;
    logic next_psr;
    logic [8:0] next_clock_selects;
    logic [31:0] next_readdata;
    logic next_irq;
    logic next_answered;
    logic wr_go;
    logic [7:0] wbyte;
    logic [7:0] flag_set;
    logic [7:0] flag_ack;
    logic [7:0] ext_set;
    logic [7:0] ext_ack;
    logic [3:0] taps;
    logic [2:0] tclk;

    // One wait state: every request answered on its second edge
    // Write lands only at the edge where waitrequest is seen low
    assign wr_go = write && answered;
    assign wbyte = byteenable[0] ? writedata[7:0] : 8'h00;

    function automatic logic cap_set(input tfp_events_type e);
        cap_set = e.capture_is_top ? e.reached_top : e.capture_event;
    endfunction : cap_set

    // Matches set flags only in a cycle with a timer clock pulse; strobe not used
    always_comb
    begin
        flag_set = 8'h00;
        flag_set[`TFP_FLAG_T1_CAPTURE] = cap_set(t1_events);
        flag_set[`TFP_FLAG_T1_CMP_A] = t1_events.match_a && tclk[0];
        flag_set[`TFP_FLAG_T1_CMP_B] = t1_events.match_b && tclk[0];
        flag_set[`TFP_FLAG_T1_OVF] = t1_events.overflow && tclk[0];
        ext_set = 8'h00;
        ext_set[`TFP_EXT_T3_CAPTURE] = cap_set(t3_events);
        ext_set[`TFP_EXT_T3_CMP_A] = t3_events.match_a && tclk[2];
        ext_set[`TFP_EXT_T3_CMP_B] = t3_events.match_b && tclk[2];
        ext_set[`TFP_EXT_T3_OVF] = t3_events.overflow && tclk[2];
        ext_set[`TFP_EXT_T3_CMP_C] = t3_events.match_c && tclk[2];
        ext_set[`TFP_EXT_T1_CMP_C] = t1_events.match_c && tclk[0];
        flag_ack = 8'h00;
        flag_ack[`TFP_FLAG_T1_CAPTURE] = t1_ack.capture;
        flag_ack[`TFP_FLAG_T1_CMP_A] = t1_ack.cmp_a;
        flag_ack[`TFP_FLAG_T1_CMP_B] = t1_ack.cmp_b;
        flag_ack[`TFP_FLAG_T1_OVF] = t1_ack.overflow;
        ext_ack = 8'h00;
        ext_ack[`TFP_EXT_T3_CAPTURE] = t3_ack.capture;
        ext_ack[`TFP_EXT_T3_CMP_A] = t3_ack.cmp_a;
        ext_ack[`TFP_EXT_T3_CMP_B] = t3_ack.cmp_b;
        ext_ack[`TFP_EXT_T3_OVF] = t3_ack.overflow;
        ext_ack[`TFP_EXT_T3_CMP_C] = t3_ack.cmp_c;
        ext_ack[`TFP_EXT_T1_CMP_C] = t1_ack.cmp_c;
        if (wr_go && address == `TFP_FLAGS_OFS)
            flag_ack = flag_ack | wbyte;
        if (wr_go && address == `TFP_EXT_FLAGS_OFS)
            ext_ack = ext_ack | wbyte;
    end

    always_comb
    begin
        // Set dominates clear
        next_flags = (flags & ~flag_ack) | flag_set;
        next_ext_flags = ((ext_flags & ~ext_ack) | ext_set) & 8'h3f;
        next_irq_enable = t1_compare_c_irq_enable;
        next_sync_mode = sync_mode_bit;
        next_psr = shared_prescaler_reset_bit && sync_mode_bit;
        next_clock_selects = clock_selects;
        if (wr_go && address == `TFP_MASK_OFS && byteenable[0])
            next_irq_enable = writedata[`TFP_MASK_T1_CMP_C];
        if (wr_go && address == `TFP_CTRL_OFS && byteenable[0])
        begin
            next_sync_mode = writedata[`TFP_CTRL_TSM];
            // Clearing sync mode drops the held reset
            next_psr = writedata[`TFP_CTRL_PSR] && writedata[`TFP_CTRL_TSM];
        end
        if (wr_go && address == `TFP_CLKSEL_OFS)
        begin
            if (byteenable[0])
                next_clock_selects[7:0] = writedata[7:0];
            if (byteenable[1])
                next_clock_selects[8] = writedata[8];
        end
        next_irq = next_irq_enable && global_irq_enable
            && next_ext_flags[`TFP_EXT_T1_CMP_C];
        next_answered = (read || write) && !answered;
        next_readdata = 32'h0000_0000;
        if (read && !answered)
        begin
            unique case (address)
                `TFP_FLAGS_OFS: next_readdata = {24'h00_0000, flags};
                `TFP_EXT_FLAGS_OFS: next_readdata = {24'h00_0000, ext_flags};
                `TFP_MASK_OFS: next_readdata = {31'h0000_0000, t1_compare_c_irq_enable};
                `TFP_CTRL_OFS: next_readdata = {24'h00_0000, sync_mode_bit, 6'h00,
                    shared_prescaler_reset_bit};
                `TFP_CLKSEL_OFS: next_readdata = {23'h00_0000, clock_selects};
                default: next_readdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            flags <= `TFP_FLAGS_RST;
            ext_flags <= `TFP_FLAGS_RST;
            t1_compare_c_irq_enable <= 1'b0;
            sync_mode_bit <= 1'b0;
            shared_prescaler_reset_bit <= 1'b0;
            clock_selects <= 9'h000;
            readdata <= 32'h0000_0000;
            t1_compare_c_irq <= 1'b0;
            answered <= 1'b0;
            timer_clocks <= 3'b000;
        end
        else
        begin
            flags <= next_flags;
            ext_flags <= next_ext_flags;
            t1_compare_c_irq_enable <= next_irq_enable;
            sync_mode_bit <= next_sync_mode;
            shared_prescaler_reset_bit <= next_psr;
            clock_selects <= next_clock_selects;
            readdata <= next_readdata;
            t1_compare_c_irq <= next_irq;
            answered <= next_answered;
            timer_clocks <= tclk;
        end
    end

    assign waitrequest = (read || write) && !answered;

    // Write of the reset bit acts at once on the shared divider
    tfp_prescaler u_prescaler (
        .clock(clock),
        .rst_n(rst_n),
        .prescaler_reset(shared_prescaler_reset_bit || (wr_go && address == `TFP_CTRL_OFS
            && byteenable[0] && writedata[`TFP_CTRL_PSR])),
        .taps(taps)
    );

    tfp_clock_select u_sel1 (
        .clock(clock),
        .rst_n(rst_n),
        .ext_pin(t1_ext_timer_clock_pin),
        .clock_select(tfp_clock_select_type'(clock_selects[2:0])),
        .taps(taps),
        .timer_clock(tclk[0])
    );
    tfp_clock_select u_sel2 (
        .clock(clock),
        .rst_n(rst_n),
        .ext_pin(t2_ext_timer_clock_pin),
        .clock_select(tfp_clock_select_type'(clock_selects[5:3])),
        .taps(taps),
        .timer_clock(tclk[1])
    );
    tfp_clock_select u_sel3 (
        .clock(clock),
        .rst_n(rst_n),
        .ext_pin(t3_ext_timer_clock_pin),
        .clock_select(tfp_clock_select_type'(clock_selects[8:6])),
        .taps(taps),
        .timer_clock(tclk[2])
    );

    irq_gate_a: assert property (@(posedge clock) disable iff (!rst_n)
        t1_compare_c_irq |-> $past(t1_compare_c_irq_enable || next_irq_enable)
        && ext_flags[`TFP_EXT_T1_CMP_C]) else $error("Irq without enable or flag");
    set_wins_a: assert property (@(posedge clock) disable iff (!rst_n)
        flag_set[`TFP_FLAG_T1_CMP_A] |=> flags[`TFP_FLAG_T1_CMP_A])
        else $error("Compare A set lost");
    w1c_clear_a: assert property (@(posedge clock) disable iff (!rst_n)
        wr_go && address == `TFP_FLAGS_OFS && byteenable[0] && writedata[`TFP_FLAG_T1_OVF]
        && !flag_set[`TFP_FLAG_T1_OVF] |=> !flags[`TFP_FLAG_T1_OVF])
        else $error("Write one did not clear");
    zero_keeps_a: assert property (@(posedge clock) disable iff (!rst_n)
        !flag_ack[`TFP_FLAG_T1_CAPTURE] && flags[`TFP_FLAG_T1_CAPTURE]
        |=> flags[`TFP_FLAG_T1_CAPTURE]) else $error("Flag lost without clear");
    capture_set_a: assert property (@(posedge clock) disable iff (!rst_n)
        t1_events.capture_event && !t1_events.capture_is_top
        |=> flags[`TFP_FLAG_T1_CAPTURE]) else $error("Capture flag not set");
    psr_self_clear_a: assert property (@(posedge clock) disable iff (!rst_n)
        shared_prescaler_reset_bit && !sync_mode_bit |=> !shared_prescaler_reset_bit)
        else $error("Reset bit stuck");
    reserved_zero_a: assert property (@(posedge clock) disable iff (!rst_n)
        ext_flags[7:6] == 2'b00) else $error("Reserved flag bits set");
    bus_answer_a: assert property (@(posedge clock) disable iff (!rst_n)
        (read || write) && waitrequest |=> !waitrequest)
        else $error("Answer late");
endmodule : tfp_timer_flags

// ===== hw/tfp_params.svh
// Offsets, field positions, reset values and prescaler taps for the timer flag block.
// Assumes a byte-addressed Avalon-MM slave with 32-bit data.
`ifndef TFP_PARAMS_SVH
`define TFP_PARAMS_SVH
`define TFP_FLAGS_OFS 8'h36
`define TFP_EXT_FLAGS_OFS 8'h7c
`define TFP_MASK_OFS 8'h40
`define TFP_CTRL_OFS 8'h44
`define TFP_CLKSEL_OFS 8'h48
`define TFP_FLAGS_RST 8'h00
`define TFP_MASK_RST 8'h00
`define TFP_FLAG_T1_CAPTURE 5
`define TFP_FLAG_T1_CMP_A 4
`define TFP_FLAG_T1_CMP_B 3
`define TFP_FLAG_T1_OVF 2
`define TFP_EXT_T3_CAPTURE 5
`define TFP_EXT_T3_CMP_A 4
`define TFP_EXT_T3_CMP_B 3
`define TFP_EXT_T3_OVF 2
`define TFP_EXT_T3_CMP_C 1
`define TFP_EXT_T1_CMP_C 0
`define TFP_CTRL_PSR 0
`define TFP_CTRL_TSM 7
`define TFP_MASK_T1_CMP_C 0
`define TFP_DIV_8 10'd7
`define TFP_DIV_64 10'd63
`define TFP_DIV_256 10'd255
`define TFP_DIV_1024 10'd1023
`endif

// ===== hw/tfp_pkg.sv
// Types shared by the timer flag and prescaler block.
// Assumes tfp_params.svh holds the numeric constants.
package tfp_pkg;
    typedef enum logic [2:0] {
        TFP_CS_STOP = 3'b000,
        TFP_CS_DIRECT = 3'b001,
        TFP_CS_DIV8 = 3'b010,
        TFP_CS_DIV64 = 3'b011,
        TFP_CS_DIV256 = 3'b100,
        TFP_CS_DIV1024 = 3'b101,
        TFP_CS_EXT_FALL = 3'b110,
        TFP_CS_EXT_RISE = 3'b111
    } tfp_clock_select_type;

    // Per-timer event inputs from the counter units
    typedef struct packed {
        logic capture_event;
        logic reached_top;
        logic capture_is_top;
        logic match_a;
        logic match_b;
        logic match_c;
        logic overflow;
        logic timer_tick;
    } tfp_events_type;

    // Per-timer vector-executed acknowledges
    typedef struct packed {
        logic capture;
        logic cmp_a;
        logic cmp_b;
        logic cmp_c;
        logic overflow;
    } tfp_ack_type;
endpackage : tfp_pkg

// ===== hw/tfp_prescaler.sv
// Free-running shared prescaler producing the divided tick taps.
// Assumes one system clock; reset input comes from the shared reset bit.
`timescale 1ns/1ps
`include "tfp_params.svh"
module tfp_prescaler
    import tfp_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic prescaler_reset,
    output logic [3:0] taps
);
    logic [9:0] count;
    logic [9:0] next_count;

    function automatic logic tap_hit(input logic [9:0] c, input logic [9:0] m);
        tap_hit = ((c & m) == m);
    endfunction : tap_hit

    always_comb
    begin
        // Runs regardless of any clock select
        next_count = prescaler_reset ? 10'h000 : count + 10'd1;
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
            count <= 10'h000;
        else
            count <= next_count;
    end

    // One-cycle pulse each divisor period
    assign taps[0] = !prescaler_reset && tap_hit(count, `TFP_DIV_8);
    assign taps[1] = !prescaler_reset && tap_hit(count, `TFP_DIV_64);
    assign taps[2] = !prescaler_reset && tap_hit(count, `TFP_DIV_256);
    assign taps[3] = !prescaler_reset && tap_hit(count, `TFP_DIV_1024);

    tap_period_a: assert property (@(posedge clock) disable iff (!rst_n)
        taps[0] |=> !taps[0] [*7]) else $error("Divide-by-8 tap too frequent");
endmodule : tfp_prescaler

// ===== hw/tfp_clock_select.sv
// Pin synchroniser, edge detector and clock-select mux for one timer.
// Assumes taps come from the shared prescaler on the same clock.
`timescale 1ns/1ps
`include "tfp_params.svh"
module tfp_clock_select
    import tfp_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic ext_pin,
    input wire tfp_clock_select_type clock_select,
    input wire logic [3:0] taps,
    output logic timer_clock
);
    logic sync_a;
    logic sync_b;
    logic sync_prev;
    logic next_timer_clock;
    logic rise;
    logic fall;

    // Latch half-cycle modelled as a register pair; latency 2.5-3.5
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            sync_a <= 1'b0;
            sync_b <= 1'b0;
            sync_prev <= 1'b0;
            timer_clock <= 1'b0;
        end
        else
        begin
            sync_a <= ext_pin;
            sync_b <= sync_a;
            sync_prev <= sync_b;
            timer_clock <= next_timer_clock;
        end
    end

    assign rise = sync_b && !sync_prev;
    assign fall = !sync_b && sync_prev;

    always_comb
    begin
        unique case (clock_select)
            TFP_CS_STOP: next_timer_clock = 1'b0;
            TFP_CS_DIRECT: next_timer_clock = 1'b1;
            TFP_CS_DIV8: next_timer_clock = taps[0];
            TFP_CS_DIV64: next_timer_clock = taps[1];
            TFP_CS_DIV256: next_timer_clock = taps[2];
            TFP_CS_DIV1024: next_timer_clock = taps[3];
            TFP_CS_EXT_FALL: next_timer_clock = fall;
            TFP_CS_EXT_RISE: next_timer_clock = rise;
        endcase
    end

    ext_rise_a: assert property (@(posedge clock) disable iff (!rst_n)
        (clock_select == TFP_CS_EXT_RISE) && $rose(sync_b) ##1
        (clock_select == TFP_CS_EXT_RISE) |-> timer_clock)
        else $error("Rising edge missed");
    stop_clock_a: assert property (@(posedge clock) disable iff (!rst_n)
        $past(clock_select) == TFP_CS_STOP |-> !timer_clock)
        else $error("Clock with select zero");
endmodule : tfp_clock_select

// ===== bench/tfp_ext_source.sv
// External clock source for one timer pin.
// Assumes the bench clock; the pin only moves just after a rising edge.
`timescale 1ns/1ps
module tfp_ext_source
(
    input wire logic clock,
    input wire logic run,
    input wire logic [3:0] half_period,
    output logic pin
);
    logic [3:0] count;

    initial
    begin
        pin = 1'b0;
        count = 4'h0;
    end

    // Pin holds its level while stopped, so select changes are safe
    always @(posedge clock)
    begin
        if (!run)
            count <= 4'h0;
        else if (count + 4'h1 >= half_period)
        begin
            count <= 4'h0;
            pin <= ~pin;
        end
        else
            count <= count + 4'h1;
    end
endmodule : tfp_ext_source

// ===== bench/tb_top.sv
// Self-checking bench for the timer flag and prescaler block.
// Assumes one 20 MHz clock and an Avalon-MM slave with one wait state.
`timescale 1ns/1ps
`include "tfp_params.svh"
module tb_top
    import tfp_pkg::*;
;
    typedef struct {
        string name;
        logic [31:0] value;
    } tfp_note_type;
    tfp_note_type notes[$];
    tfp_note_type note;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [7:0] address = 8'h00;
    logic [31:0] writedata = 32'h0000_0000;
    logic [3:0] byteenable = 4'hf;
    logic [31:0] readdata;
    logic waitrequest;
    tfp_events_type t1_events = '0;
    tfp_events_type t3_events = '0;
    tfp_ack_type t1_ack = '0;
    tfp_ack_type t3_ack = '0;
    logic forced_compare_strobe = 1'b0;
    logic global_irq_enable = 1'b0;
    logic [2:0] pins;
    logic [2:0] pins_q = 3'h0;
    logic [2:0] run = 3'h0;
    logic [3:0] half = 4'h3;
    logic [2:0] timer_clocks;
    logic t1_compare_c_irq;
    int failures = 0;
    int checks = 0;
    int cyc = 0;
    int last[3];
    int period[3];
    int pulses[3];
    int rises[3];
    int falls[3];
    int rise_at[3];
    int lat[3];

    tfp_timer_flags i_tfp_timer_flags (.clock(clock), .rst_n(rst_n), .address(address),
        .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
        .readdata(readdata), .waitrequest(waitrequest), .t1_events(t1_events),
        .t3_events(t3_events), .t1_ack(t1_ack), .t3_ack(t3_ack),
        .forced_compare_strobe(forced_compare_strobe), .global_irq_enable(global_irq_enable),
        .t1_ext_timer_clock_pin(pins[0]), .t2_ext_timer_clock_pin(pins[1]),
        .t3_ext_timer_clock_pin(pins[2]), .timer_clocks(timer_clocks),
        .t1_compare_c_irq(t1_compare_c_irq));

    for (genvar g = 0; g < 3; g++)
    begin : src
        tfp_ext_source i_tfp_ext_source (.clock(clock), .run(run[g]), .half_period(half),
            .pin(pins[g]));
    end

    always #25 clock = ~clock;

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic wrap_up;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : wrap_up

    // Request stays up until waitrequest is seen low at a rising edge
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock);
        address <= a;
        writedata <= d;
        read <= ~wr;
        write <= wr;
        do
        begin
            @(posedge clock);
            n++;
        end
        while (waitrequest !== 1'b0 && n < 50);
        if (n >= 50)
            failures++;
        read <= 1'b0;
        write <= 1'b0;
    endtask : bus

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
        notes.push_back('{n, e});
        bus(1'b0, a, 32'h0000_0000);
    endtask : rd

    task automatic ev(input logic [7:0] a, input logic [7:0] b);
        @(posedge clock);
        t1_events <= a;
        t3_events <= b;
        @(posedge clock);
        t1_events <= '0;
        t3_events <= '0;
    endtask : ev

    task automatic cycles(input int n);
        repeat (n) @(posedge clock);
    endtask : cycles

    // Cleared off the edge so the monitor never races the reset
    task automatic clr;
        @(negedge clock);
        pulses = '{0, 0, 0};
        rises = '{0, 0, 0};
        falls = '{0, 0, 0};
    endtask : clr

    always @(posedge clock)
    begin
        cyc++;
        if (read === 1'b1 && waitrequest === 1'b0)
        begin
            note = notes.pop_front();
            check(note.name, readdata, note.value);
        end
        for (int i = 0; i < 3; i++)
        begin
            if (pins[i] && !pins_q[i])
            begin
                rises[i]++;
                rise_at[i] = cyc;
            end
            if (!pins[i] && pins_q[i])
                falls[i]++;
            if (timer_clocks[i] === 1'b1)
            begin
                period[i] = cyc - last[i];
                last[i] = cyc;
                lat[i] = cyc - rise_at[i];
                pulses[i]++;
            end
        end
        pins_q = pins;
    end

    // Whole run is a few thousand cycles; this leaves wide margin
    initial
    begin
        #3000000;
        failures++;
        wrap_up;
    end

    initial
    begin
        logic [7:0] a;
        logic [7:0] b;
        logic [7:0] w;
        logic [7:0] e36;
        logic [7:0] e7c;
        int n;
        void'($urandom(32'hab3cf244));
        repeat (16) @(posedge clock);
        rst_n <= 1'b1;
        rd(`TFP_FLAGS_OFS, 32'h0000_0000, "flags_reset");
        rd(`TFP_EXT_FLAGS_OFS, 32'h0000_0000, "ext_reset");
        rd(`TFP_MASK_OFS, 32'h0000_0000, "mask_reset");
        bus(1'b1, 8'h10, 32'h0000_00ff);
        rd(8'h10, 32'h0000_0000, "unmapped");
        bus(1'b1, `TFP_CLKSEL_OFS, 32'h0000_0041);
        cycles(4);
        forced_compare_strobe <= 1'b1;
        cycles(3);
        forced_compare_strobe <= 1'b0;
        rd(`TFP_FLAGS_OFS, 32'h0000_0000, "forced");
        rd(`TFP_EXT_FLAGS_OFS, 32'h0000_0000, "forced_ext");
        e36 = 8'h00;
        e7c = 8'h00;
        repeat (3)
        begin
            a = 8'($urandom) & 8'h9e;
            b = 8'($urandom) & 8'h9e;
            ev(a, b);
            e36 |= {2'b00, a[7], a[4], a[3], a[1], 2'b00};
            e7c |= {2'b00, b[7], b[4], b[3], b[1], b[2], a[2]};
        end
        rd(`TFP_FLAGS_OFS, {24'h00_0000, e36}, "flags_set");
        rd(`TFP_EXT_FLAGS_OFS, {24'h00_0000, e7c}, "ext_set");
        w = 8'($urandom) & 8'h3c;
        bus(1'b1, `TFP_FLAGS_OFS, {24'h00_0000, w});
        e36 &= ~w;
        w = 8'($urandom) & 8'h3f;
        bus(1'b1, `TFP_EXT_FLAGS_OFS, {24'h00_0000, w});
        e7c &= ~w;
        rd(`TFP_FLAGS_OFS, {24'h00_0000, e36}, "flags_w1c");
        rd(`TFP_EXT_FLAGS_OFS, {24'h00_0000, e7c}, "ext_w1c");
        ev(8'h7e, 8'h7e);
        rd(`TFP_FLAGS_OFS, 32'h0000_003c, "flags_top");
        rd(`TFP_EXT_FLAGS_OFS, 32'h0000_003f, "ext_top");
        for (int k = 0; k < 4; k++)
        begin
            bus(1'b1, `TFP_MASK_OFS, 32'(k & 1));
            global_irq_enable <= k[1];
            cycles(3);
            check("irq", t1_compare_c_irq, k[0] & k[1]);
        end
        rd(`TFP_MASK_OFS, 32'h0000_0001, "mask");
        @(posedge clock);
        t1_ack <= 5'h1f;
        t3_ack <= 5'h15;
        @(posedge clock);
        t1_ack <= 5'h00;
        t3_ack <= 5'h00;
        rd(`TFP_FLAGS_OFS, 32'h0000_0000, "flags_ack");
        rd(`TFP_EXT_FLAGS_OFS, 32'h0000_0012, "ext_ack");
        check("irq_off", t1_compare_c_irq, 1'b0);
        bus(1'b1, `TFP_EXT_FLAGS_OFS, 32'h0000_003f);
        for (int k = 0; k < 4; k++)
        begin
            bus(1'b1, `TFP_CLKSEL_OFS, 32'h0000_0050 | 32'(k + 2));
            n = (k < 2) ? (8 << (3 * k)) : (256 << (2 * (k - 2)));
            cycles(2 * n + 20);
            check("tap", period[0], n);
            check("tap_t2", period[1], 8);
            check("direct", period[2], 1);
        end
        bus(1'b1, `TFP_CLKSEL_OFS, 32'h0000_0000);
        cycles(3);
        clr;
        ev(8'h1e, 8'h1e);
        cycles(40);
        check("stopped", pulses[0] + pulses[1] + pulses[2], 0);
        rd(`TFP_FLAGS_OFS, 32'h0000_0000, "stop_flags");
        bus(1'b1, `TFP_CLKSEL_OFS, 32'h0000_009b);
        cycles(300);
        bus(1'b1, `TFP_CTRL_OFS, 32'h0000_0001);
        clr;
        n = 0;
        while (pulses[0] == 0 && n < 200)
        begin
            @(negedge clock);
            n++;
        end
        check("same_phase", last[0], last[1]);
        check("restart", n >= 60 && n <= 66, 1'b1);
        rd(`TFP_CTRL_OFS, 32'h0000_0000, "self_clear");
        bus(1'b1, `TFP_CTRL_OFS, 32'h0000_0081);
        rd(`TFP_CTRL_OFS, 32'h0000_0081, "held");
        cycles(3);
        clr;
        cycles(100);
        check("halted", pulses[2], 0);
        bus(1'b1, `TFP_CTRL_OFS, 32'h0000_0000);
        rd(`TFP_CTRL_OFS, 32'h0000_0000, "released");
        cycles(30);
        check("resumed", pulses[2] > 0, 1'b1);
        bus(1'b1, `TFP_CLKSEL_OFS, 32'h0000_01f7);
        cycles(4);
        clr;
        @(posedge clock);
        half <= 4'(3 + $urandom % 3);
        run <= 3'h7;
        cycles(300);
        run <= 3'h0;
        cycles(10);
        check("edges", rises[0] > 10, 1'b1);
        check("rise_t1", pulses[0], rises[0]);
        check("fall_t2", pulses[1], falls[1]);
        check("rise_t3", pulses[2], rises[2]);
        check("latency", lat[0] >= 2 && lat[0] <= 5, 1'b1);
        wrap_up;
    end
endmodule : tb_top
